// *** design/eacs_pkg.sv ***
package eacs_pkg;
   // register byte offsets
   localparam logic [15:0] OFS_NEG_CTRL1   = 16'h00e0;
   localparam logic [15:0] OFS_NEG_CTRL2   = 16'h00e4;
   localparam logic [15:0] OFS_NEG_ABILITY = 16'h00f8;
   localparam logic [15:0] OFS_TRN_CTRL    = 16'h0100;
   localparam logic [15:0] OFS_TRN_RXDONE  = 16'h0104;
   localparam logic [15:0] OFS_TRN_PRESET  = 16'h0108;
   localparam logic [15:0] OFS_TRN_INIT    = 16'h010c;
   localparam logic [15:0] OFS_TRN_SEED01  = 16'h0110;
   localparam logic [15:0] OFS_TRN_SEED23  = 16'h0114;
   localparam logic [15:0] OFS_TRN_COEF01  = 16'h0130;
   localparam logic [15:0] OFS_TRN_COEF23  = 16'h0134;
   localparam logic [15:0] OFS_USER        = 16'h0138;
   localparam logic [15:0] OFS_SPEED_SW    = 16'h013c;
   localparam logic [15:0] OFS_TX_STAT     = 16'h0400;
   localparam logic [15:0] OFS_RX_STAT     = 16'h0404;
   localparam logic [15:0] OFS_FIFO_STAT   = 16'h0408;

   // configuration word indices
   localparam int CFG_N        = 12;
   localparam int IDX_NEG1     = 0;
   localparam int IDX_SEED_POS = 1;

   // writable bits of each configuration word
   localparam logic [CFG_N-1:0][31:0] CFG_MASK = {
      32'hffffffff, 32'h0fff0fff, 32'h0fff0fff, 32'h07ff07ff,
      32'h07ff07ff, 32'h0000000f, 32'h0000000f, 32'h0000000f,
      32'h00000003, 32'h00007fff, 32'h003f0003, 32'h00001fff};

   // values after reset, bit positions and status bit masks
   localparam logic [31:0] NEG1_RESET   = 32'h00000002;
   localparam int          NEG1_BYPASS  = 1;
   localparam logic [31:0] CFG_RESET    = 32'h00000000;
   localparam int          SW_REQ_BIT   = 0;
   localparam logic [11:0] RX_RESET     = 12'h003;
   localparam logic [11:0] RX_LOW_MASK  = 12'h003;
   localparam logic [11:0] RX_BASE_MASK = 12'h05f;
   localparam logic [11:0] RX_MAC_MASK  = 12'hfa0;
   localparam logic [16:0] FIFO_MAC     = 17'h00030;
   localparam logic [16:0] FIFO_WIDE    = 17'h00006;
   localparam logic [16:0] FIFO_PCS     = 17'h10001;

   // build variants
   typedef enum logic [1:0] {
      VAR_MAC_PCS  = 2'b00,
      VAR_PCS_ONLY = 2'b01
   } eacs_variant_t;

   // live status conditions from the core
   typedef struct packed {
      logic        txLocalFault;
      logic [11:0] rxLive;
      logic [16:0] fifoLive;
   } eacs_stat_t;

   // configuration words driven to the core
   typedef struct packed {
      logic [CFG_N-1:0][31:0] word;
   } eacs_cfg_t;
endpackage

// *** design/eacs_regs.sv ***
// Functional notes
// - A sticky-high bit holds 1 after its condition, until released.
// - A sticky-low bit stays 0 after its condition drops, until release.
// - Writing 1 to the speed request bit starts a 40G/50G rate switch.
// - The speed request bit clears itself so it acts as a one-shot.
// - Without runtime rate switching the request bit has no effect.
// - The request pulse goes to the transceiver reconfiguration helper.
// - Reset loads the negotiation-skip bit with 1.
// - Fault, framing, signal-set, timing FIFO bits exist only with MAC.
// - Underflow/overflow bits exist only in the wide 40G MAC build.
// - TX and RX FIFO error bits exist only in the PCS-only build.
`timescale 1ns/100ps
`default_nettype none
module eacs_regs #(
   parameter eacs_pkg::eacs_variant_t VARIANT = eacs_pkg::VAR_MAC_PCS,
   parameter bit RUNTIME_SWITCH = 1'b1,
   parameter bit WIDE_40G       = 1'b0
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   // register access port
   input  wire logic [15:0]       regAddr,
   input  wire logic              regWrEn,
   input  wire logic [31:0]       regWrData,
   input  wire logic              regRdEn,
   output var  logic [31:0]       regRdData,
   output var  logic              regRdValid,
   output var  logic              regErr,
   // core side
   input  wire eacs_pkg::eacs_stat_t statIn,
   output var  eacs_pkg::eacs_cfg_t  cfgOut,
   output var  logic              speedSwitchPulse
);

   localparam bit MAC_PCS = (VARIANT == eacs_pkg::VAR_MAC_PCS);

   // status bits present in this build
   localparam logic [11:0] RX_EXIST = eacs_pkg::RX_BASE_MASK |
      (MAC_PCS ? eacs_pkg::RX_MAC_MASK : 12'h000);
   localparam logic [16:0] FIFO_EXIST =
      (MAC_PCS ? eacs_pkg::FIFO_MAC : 17'h00000) |
      ((MAC_PCS && WIDE_40G) ? eacs_pkg::FIFO_WIDE : 17'h00000) |
      (MAC_PCS ? 17'h00000 : eacs_pkg::FIFO_PCS);

   logic [31:0]                 cfgRegs_ff [eacs_pkg::CFG_N];
   logic                        speedReq_ff;
   logic                        txHeld_ff;
   logic [11:0]                 rxHeld_ff;
   logic [16:0]                 fifoHeld_ff;
   logic [31:0]                 rdData_ff;
   logic                        rdValid_ff;
   logic                        err_ff;
   logic [31:0]                 nxt_rdData;
   logic                        nxt_err;
   logic                        cfgHit;
   logic [3:0]                  cfgIdx;
   logic                        swSel;
   logic                        txSel;
   logic                        rxSel;
   logic                        fifoSel;
   logic                        rdTx;
   logic                        rdRx;
   logic                        rdFifo;
   logic                        swReqWr;
   logic [11:0]                 rxLiveV;
   logic [16:0]                 fifoLiveV;
   logic                        txLiveV;
   logic [11:0]                 nxt_rxHeld;
   logic [16:0]                 nxt_fifoHeld;
   logic                        nxt_txHeld;

   // address decode of the configuration words
   always_comb begin
      cfgHit = 1'b1;
      cfgIdx = 4'h0;
      unique case (regAddr)
         eacs_pkg::OFS_NEG_CTRL1:   cfgIdx = 4'h0;
         eacs_pkg::OFS_NEG_CTRL2:   cfgIdx = 4'h1;
         eacs_pkg::OFS_NEG_ABILITY: cfgIdx = 4'h2;
         eacs_pkg::OFS_TRN_CTRL:    cfgIdx = 4'h3;
         eacs_pkg::OFS_TRN_RXDONE:  cfgIdx = 4'h4;
         eacs_pkg::OFS_TRN_PRESET:  cfgIdx = 4'h5;
         eacs_pkg::OFS_TRN_INIT:    cfgIdx = 4'h6;
         eacs_pkg::OFS_TRN_SEED01:  cfgIdx = 4'h7;
         eacs_pkg::OFS_TRN_SEED23:  cfgIdx = 4'h8;
         eacs_pkg::OFS_TRN_COEF01:  cfgIdx = 4'h9;
         eacs_pkg::OFS_TRN_COEF23:  cfgIdx = 4'ha;
         eacs_pkg::OFS_USER:        cfgIdx = 4'hb;
         default:                   cfgHit = 1'b0;
      endcase
   end

   // decode of the trigger and status words
   assign swSel   = (regAddr == eacs_pkg::OFS_SPEED_SW);
   assign txSel   = (regAddr == eacs_pkg::OFS_TX_STAT);
   assign rxSel   = (regAddr == eacs_pkg::OFS_RX_STAT);
   assign fifoSel = (regAddr == eacs_pkg::OFS_FIFO_STAT);
   assign rdTx    = regRdEn && txSel;
   assign rdRx    = regRdEn && rxSel;
   assign rdFifo  = regRdEn && fifoSel;
   assign swReqWr = regWrEn && swSel && regWrData[eacs_pkg::SW_REQ_BIT];

   // configuration words, negotiation skip set at reset
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         for (int i = 0; i < eacs_pkg::CFG_N; i++) begin
            cfgRegs_ff[i] <= eacs_pkg::CFG_RESET;
         end
         cfgRegs_ff[eacs_pkg::IDX_NEG1] <= eacs_pkg::NEG1_RESET;
      end else if (regWrEn && cfgHit) begin
         // software sets enable and skip freely
         cfgRegs_ff[cfgIdx] <= regWrData &
            eacs_pkg::CFG_MASK[cfgIdx];
      end
   end

   // one-shot rate switch request toward the reconfiguration helper
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         speedReq_ff <= 1'b0;
      end else begin
         speedReq_ff <= swReqWr && RUNTIME_SWITCH;
      end
   end

   // live conditions limited to bits present in the build
   assign txLiveV   = statIn.txLocalFault;
   assign rxLiveV   = statIn.rxLive & RX_EXIST;
   assign fifoLiveV = statIn.fifoLive & FIFO_EXIST;

   // sticky update, read releases to live value, new event wins
   always_comb begin
      nxt_txHeld   = rdTx ? txLiveV :
         (txHeld_ff | txLiveV);
      nxt_rxHeld   = rdRx ? rxLiveV :
         ((((rxHeld_ff | rxLiveV) & ~eacs_pkg::RX_LOW_MASK) |
           ((rxHeld_ff & rxLiveV) & eacs_pkg::RX_LOW_MASK)) & RX_EXIST);
      nxt_fifoHeld = rdFifo ? fifoLiveV :
         (fifoHeld_ff | fifoLiveV);
   end

   // sticky status flops
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         txHeld_ff   <= 1'b0;
         rxHeld_ff   <= eacs_pkg::RX_RESET & RX_EXIST;
         fifoHeld_ff <= 17'h00000;
      end else begin
         txHeld_ff   <= nxt_txHeld;
         rxHeld_ff   <= nxt_rxHeld;
         fifoHeld_ff <= nxt_fifoHeld;
      end
   end

   // read data mux, unmapped reads answer zero with error
   always_comb begin
      nxt_rdData = 32'h00000000;
      nxt_err    = 1'b0;
      if (cfgHit) begin
         nxt_rdData = cfgRegs_ff[cfgIdx];
      end else if (swSel) begin
         nxt_rdData = {31'h00000000, speedReq_ff};
      end else if (txSel) begin
         nxt_rdData = {31'h00000000, txHeld_ff};
      end else if (rxSel) begin
         nxt_rdData = {20'h00000, rxHeld_ff};
      end else if (fifoSel) begin
         nxt_rdData = {15'h0000, fifoHeld_ff};
      end else begin
         nxt_err = 1'b1;
      end
   end

   // registered read answer and access error
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rdData_ff  <= 32'h00000000;
         rdValid_ff <= 1'b0;
         err_ff     <= 1'b0;
      end else begin
         rdValid_ff <= regRdEn;
         err_ff     <= (regRdEn || regWrEn) && nxt_err;
         if (regRdEn) begin
            rdData_ff <= nxt_rdData;
         end
      end
   end

   // outputs straight from flops
   assign regRdData        = rdData_ff;
   assign regRdValid       = rdValid_ff;
   assign regErr           = err_ff;
   assign speedSwitchPulse = speedReq_ff;
   always_comb begin
      for (int i = 0; i < eacs_pkg::CFG_N; i++) begin
         cfgOut.word[i] = cfgRegs_ff[i];
      end
   end

   // checks
   property p_sticky_high;
      @(posedge sys_clk) disable iff (!resetn)
      (rxHeld_ff[2] && !rdRx) |=> rxHeld_ff[2];
   endproperty
   a_sticky_high: assert property (p_sticky_high)
      else $error("sticky high bit dropped without read");

   property p_sticky_low;
      @(posedge sys_clk) disable iff (!resetn)
      (!rxHeld_ff[0] && !rdRx) |=> !rxHeld_ff[0];
   endproperty
   a_sticky_low: assert property (p_sticky_low)
      else $error("sticky low bit rose without read");

   property p_switch_start;
      @(posedge sys_clk) disable iff (!resetn)
      (swReqWr && RUNTIME_SWITCH) |=> speedSwitchPulse;
   endproperty
   a_switch_start: assert property (p_switch_start)
      else $error("rate switch request not issued");

   property p_one_shot;
      @(posedge sys_clk) disable iff (!resetn)
      (speedSwitchPulse && !swReqWr) |=> !speedSwitchPulse;
   endproperty
   a_one_shot: assert property (p_one_shot)
      else $error("rate switch request held");

   property p_no_runtime;
      @(posedge sys_clk) disable iff (!resetn)
      !RUNTIME_SWITCH |-> !speedSwitchPulse;
   endproperty
   a_no_runtime: assert property (p_no_runtime)
      else $error("switch pulse in fixed-rate build");

   property p_forward;
      @(posedge sys_clk) disable iff (!resetn)
      speedSwitchPulse |-> ($past(regWrEn) &&
         ($past(regAddr) == eacs_pkg::OFS_SPEED_SW));
   endproperty
   a_forward: assert property (p_forward)
      else $error("switch pulse without trigger write");

   property p_bypass_reset;
      @(posedge sys_clk) disable iff (!resetn)
      $rose(resetn) |->
         cfgOut.word[eacs_pkg::IDX_NEG1][eacs_pkg::NEG1_BYPASS];
   endproperty
   a_bypass_reset: assert property (p_bypass_reset)
      else $error("negotiation skip not set after reset");

   property p_mac_bits;
      @(posedge sys_clk) disable iff (!resetn)
      ((rxHeld_ff & ~RX_EXIST) == 12'h000) &&
      ((fifoHeld_ff & ~FIFO_EXIST) == 17'h00000);
   endproperty
   a_mac_bits: assert property (p_mac_bits)
      else $error("status bit absent in build is set");

   property p_wide_bits;
      @(posedge sys_clk) disable iff (!resetn)
      !(MAC_PCS && WIDE_40G) |-> (fifoHeld_ff[2:1] == 2'b00);
   endproperty
   a_wide_bits: assert property (p_wide_bits)
      else $error("underflow or overflow bit in wrong build");

   property p_pcs_bits;
      @(posedge sys_clk) disable iff (!resetn)
      MAC_PCS |-> (!fifoHeld_ff[0] && !fifoHeld_ff[16]);
   endproperty
   a_pcs_bits: assert property (p_pcs_bits)
      else $error("fifo error bit in MAC build");

   property p_read_release;
      @(posedge sys_clk) disable iff (!resetn)
      rdRx |=> (rxHeld_ff == $past(rxLiveV)) ##0
         (regRdData == {20'h00000, $past(rxHeld_ff)});
   endproperty
   a_read_release: assert property (p_read_release)
      else $error("read did not release sticky bits");

   property p_tx_sets;
      @(posedge sys_clk) disable iff (!resetn)
      txLiveV |=> txHeld_ff;
   endproperty
   a_tx_sets: assert property (p_tx_sets)
      else $error("tx fault not latched");

   property p_rx_sets;
      @(posedge sys_clk) disable iff (!resetn)
      ((rxLiveV & ~eacs_pkg::RX_LOW_MASK) != 12'h000) |=>
         ((rxHeld_ff & $past(rxLiveV) & ~eacs_pkg::RX_LOW_MASK) ==
          ($past(rxLiveV) & ~eacs_pkg::RX_LOW_MASK));
   endproperty
   a_rx_sets: assert property (p_rx_sets)
      else $error("rx sticky high bit not latched");

   property p_low_drop;
      @(posedge sys_clk) disable iff (!resetn)
      ((rxLiveV & eacs_pkg::RX_LOW_MASK) != eacs_pkg::RX_LOW_MASK) |=>
         ((rxHeld_ff & ~$past(rxLiveV) & eacs_pkg::RX_LOW_MASK) == 12'h000);
   endproperty
   a_low_drop: assert property (p_low_drop)
      else $error("sticky low bit did not drop");

   property p_low_hold1;
      @(posedge sys_clk) disable iff (!resetn)
      (!rxHeld_ff[1] && !rdRx) |=> !rxHeld_ff[1];
   endproperty
   a_low_hold1: assert property (p_low_hold1)
      else $error("second sticky low bit rose without read");

   property p_tx_release;
      @(posedge sys_clk) disable iff (!resetn)
      rdTx |=> (txHeld_ff == $past(txLiveV));
   endproperty
   a_tx_release: assert property (p_tx_release)
      else $error("tx read did not release sticky bit");

   property p_fifo_release;
      @(posedge sys_clk) disable iff (!resetn)
      rdFifo |=> (fifoHeld_ff == $past(fifoLiveV));
   endproperty
   a_fifo_release: assert property (p_fifo_release)
      else $error("fifo read did not release sticky bits");

   property p_write_lands;
      @(posedge sys_clk) disable iff (!resetn)
      (regWrEn && cfgHit) |=> (cfgOut.word[$past(cfgIdx)] ==
         ($past(regWrData) & eacs_pkg::CFG_MASK[$past(cfgIdx)]));
   endproperty
   a_write_lands: assert property (p_write_lands)
      else $error("configuration write not stored under mask");

   property p_skip_held;
      @(posedge sys_clk) disable iff (!resetn)
      (cfgOut.word[eacs_pkg::IDX_NEG1][eacs_pkg::NEG1_BYPASS] &&
       !(regWrEn && cfgHit && (cfgIdx == eacs_pkg::IDX_NEG1))) |=>
         cfgOut.word[eacs_pkg::IDX_NEG1][eacs_pkg::NEG1_BYPASS];
   endproperty
   a_skip_held: assert property (p_skip_held)
      else $error("negotiation skip cleared without write");

   property p_switch_data;
      @(posedge sys_clk) disable iff (!resetn)
      speedSwitchPulse |-> $past(regWrData[eacs_pkg::SW_REQ_BIT]);
   endproperty
   a_switch_data: assert property (p_switch_data)
      else $error("switch pulse without request bit written");

endmodule // eacs_regs
`default_nettype wire

// *** testbench/eacs_regs_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin failCount++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module eacs_regs_bench;
   // one table row: access, data written, value expected back
   typedef struct packed {
      logic [15:0] addr;
      logic [31:0] wdata;
      logic [31:0] expVal;
      int          idx;
   } eacs_row_t;

   // configuration offsets in word order
   localparam logic [15:0] OFS [12] = '{eacs_pkg::OFS_NEG_CTRL1,
      eacs_pkg::OFS_NEG_CTRL2, eacs_pkg::OFS_NEG_ABILITY,
      eacs_pkg::OFS_TRN_CTRL, eacs_pkg::OFS_TRN_RXDONE,
      eacs_pkg::OFS_TRN_PRESET, eacs_pkg::OFS_TRN_INIT,
      eacs_pkg::OFS_TRN_SEED01, eacs_pkg::OFS_TRN_SEED23,
      eacs_pkg::OFS_TRN_COEF01, eacs_pkg::OFS_TRN_COEF23,
      eacs_pkg::OFS_USER};

   logic                 sys_clk;
   logic                 resetn;
   logic [15:0]          regAddr;
   logic                 regWrEn;
   logic                 regRdEn;
   logic [31:0]          regWrData;
   logic [31:0]          rdData;
   logic [31:0]          rdData2;
   logic [31:0]          rdData3;
   logic [31:0]          got;
   logic [31:0]          got2;
   logic [31:0]          got3;
   logic [31:0]          expV;
   logic                 regRdValid;
   logic                 regErr;
   logic                 speedSwitchPulse;
   logic                 pulse2;
   eacs_pkg::eacs_stat_t statIn;
   eacs_pkg::eacs_cfg_t  cfgOut;
   eacs_row_t            rows [13];
   int                   failCount;
   int                   testsRun;

   // full build with runtime switching
   eacs_regs dut_u (
      .sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
      .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
      .regRdData(rdData), .regRdValid(regRdValid), .regErr(regErr),
      .statIn(statIn), .cfgOut(cfgOut),
      .speedSwitchPulse(speedSwitchPulse));

   // pcs-only build without runtime switching, same stimulus
   eacs_regs #(.VARIANT(eacs_pkg::VAR_PCS_ONLY), .RUNTIME_SWITCH(1'b0))
   dut_pcs_u (
      .sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
      .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
      .regRdData(rdData2), .regRdValid(), .regErr(),
      .statIn(statIn), .cfgOut(), .speedSwitchPulse(pulse2));

   // wide 40G build, same stimulus
   eacs_regs #(.WIDE_40G(1'b1))
   dut_wide_u (
      .sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
      .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
      .regRdData(rdData3), .regRdValid(), .regErr(),
      .statIn(statIn), .cfgOut(), .speedSwitchPulse());

   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;

   task automatic wrapUp;
      $display("comparisons %0d mismatches %0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic doReset;
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
   endtask

   // one write, returns just after the taking edge
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regAddr   <= a;
      regWrData <= d;
      regWrEn   <= 1'b1;
      @(posedge sys_clk);
      regWrEn <= 1'b0;
      #1;
   endtask

   // one read, answer of all three builds captured
   task automatic rd(input logic [15:0] a);
      @(posedge sys_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge sys_clk);
      regRdEn <= 1'b0;
      #1;
      `CHK(regRdValid, 1'b1)
      got  = rdData;
      got2 = rdData2;
      got3 = rdData3;
   endtask

   // live condition for one cycle, then back to idle
   task automatic statPulse(input eacs_pkg::eacs_stat_t s);
      @(posedge sys_clk);
      statIn <= s;
      @(posedge sys_clk);
      statIn <= '{1'b0, 12'h003, 17'h0};
   endtask

   // hang guard, tests need well under 1000 cycles
   initial begin
      #20000;
      failCount++;
      wrapUp;
   end

   // main sequence
   initial begin
      sys_clk = 1'b0;
      resetn = 1'b0;
      regAddr = 16'h0;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regWrData = 32'h0;
      statIn = '{1'b0, 12'h003, 17'h0};
      failCount = 0;
      testsRun = 0;
      doReset;
      for (int i = 0; i < 12; i++)
         rows[i] = '{OFS[i], 32'hffffffff, eacs_pkg::CFG_MASK[i], i};
      rows[12] = '{eacs_pkg::OFS_NEG_CTRL1, 32'h00000001, 32'h00000001, 0};
      foreach (rows[r]) begin
         wr(rows[r].addr, rows[r].wdata);
         `CHK(cfgOut.word[rows[r].idx], rows[r].expVal)
         rd(rows[r].addr);
         `CHK(got, rows[r].expVal)
      end
      `CHK(cfgOut.word[eacs_pkg::IDX_NEG1], 32'h00000001)
      // second reset in mid-run restores defaults
      doReset;
      expV = cfgOut.word[eacs_pkg::IDX_NEG1];
      `CHK(expV[eacs_pkg::NEG1_BYPASS], 1'b1)
      for (int i = 0; i < 12; i++) begin
         rd(OFS[i]);
         expV = (i == 0) ? eacs_pkg::NEG1_RESET : eacs_pkg::CFG_RESET;
         `CHK(got, expV)
      end
      rd(eacs_pkg::OFS_RX_STAT);
      `CHK(got, {20'h0, eacs_pkg::RX_RESET})
      // sticky-high bits and build-dependent presence
      statPulse('{1'b1, 12'hfff, 17'h1ffff});
      repeat (2) @(posedge sys_clk);
      rd(eacs_pkg::OFS_TX_STAT);
      `CHK(got, 32'h00000001)
      rd(eacs_pkg::OFS_RX_STAT);
      `CHK(got, 32'h00000fff)
      `CHK(got2, {20'h0, eacs_pkg::RX_BASE_MASK})
      rd(eacs_pkg::OFS_FIFO_STAT);
      `CHK(got, {15'h0, eacs_pkg::FIFO_MAC})
      `CHK(got2, {15'h0, eacs_pkg::FIFO_PCS})
      `CHK(got3, {15'h0, eacs_pkg::FIFO_MAC | eacs_pkg::FIFO_WIDE})
      rd(eacs_pkg::OFS_RX_STAT);
      `CHK(got, 32'h00000003)
      rd(eacs_pkg::OFS_FIFO_STAT);
      `CHK(got, 32'h00000000)
      // sticky-low bit drops once and stays down until read
      statPulse('{1'b0, 12'h002, 17'h0});
      repeat (2) @(posedge sys_clk);
      rd(eacs_pkg::OFS_RX_STAT);
      `CHK(got, 32'h00000002)
      rd(eacs_pkg::OFS_RX_STAT);
      `CHK(got, 32'h00000003)
      // speed switch one-shot
      wr(eacs_pkg::OFS_SPEED_SW, 32'h00000001);
      `CHK(speedSwitchPulse, 1'b1)
      `CHK(pulse2, 1'b0)
      @(posedge sys_clk);
      #1;
      `CHK(speedSwitchPulse, 1'b0)
      rd(eacs_pkg::OFS_SPEED_SW);
      `CHK(got, 32'h00000000)
      wr(eacs_pkg::OFS_SPEED_SW, 32'hfffffffe);
      `CHK(speedSwitchPulse, 1'b0)
      // unmapped and read-only places
      wr(16'h0200, 32'hffffffff);
      `CHK(regErr, 1'b1)
      rd(16'h0200);
      `CHK(regErr, 1'b1)
      `CHK(got, 32'h00000000)
      wr(eacs_pkg::OFS_TX_STAT, 32'hffffffff);
      `CHK(regErr, 1'b0)
      rd(eacs_pkg::OFS_TX_STAT);
      `CHK(got, 32'h00000000)
      wrapUp;
   end
endmodule // eacs_regs_bench
`undef CHK
`default_nettype wire
